/* acc_pkg.sv */
// Package of constants and types for the analog comparator control block
package acc_pkg;

  // ---------------------------------------------------------------------
  // Channel select encodings
  // ---------------------------------------------------------------------
  localparam logic [2:0] ACC_SEL_GND  = 3'h7;
  localparam logic [2:0] ACC_SEL_REF  = 3'h6;
  localparam logic [2:0] ACC_SEL_DAC  = 3'h5;
  localparam logic [2:0] ACC_SEL_PIN3 = 3'h3;
  localparam logic [2:0] ACC_SEL_PIN0 = 3'h0;

  // ---------------------------------------------------------------------
  // One-hot source codes on the analog mux controls
  // ---------------------------------------------------------------------
  localparam int ACC_POS_PIN0_BIT = 0;
  localparam int ACC_POS_DAC_BIT  = 1;
  localparam int ACC_POS_REF_BIT  = 2;
  localparam int ACC_POS_GND_BIT  = 3;
  localparam int ACC_NEG_REF_BIT  = 4;
  localparam int ACC_NEG_GND_BIT  = 5;

  // ---------------------------------------------------------------------
  // Reset values, counts and field widths
  // ---------------------------------------------------------------------
  localparam logic       ACC_OUT_RST      = 1'b0;
  localparam logic       ACC_FLAG_RST     = 1'b0;
  localparam int         ACC_NUM_CMP      = 2;
  localparam int         ACC_MIRROR_W     = 8;
  localparam logic [7:0] ACC_MIRROR_RST   = 8'h00;
  localparam int         ACC_SETTLE_CYC   = 4;

  // ---------------------------------------------------------------------
  // Carried groups
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic       enable;
    logic       invert;
    logic       hysteresis;
    logic       timer_sync;
    logic       rise_irq_en;
    logic       fall_irq_en;
    logic [2:0] pos_sel;
    logic [2:0] neg_sel;
  } acc_cfg_t;

  typedef struct packed {
    logic       pos_pin0;
    logic       pos_dac;
    logic       pos_ref;
    logic       pos_gnd;
    logic [3:0] neg_pin;
    logic       neg_ref;
    logic       neg_gnd;
    logic       hyst_on;
    logic       power_on;
  } acc_ana_t;

endpackage : acc_pkg

/* acc_ctrl.sv */
// Digital control of two analog comparators: muxing, polarity, flags
`timescale 1ns/1ps
`default_nettype none

module acc_ctrl
  import acc_pkg::*;
#(
  parameter int SETTLE_CYC = ACC_SETTLE_CYC
) (
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_b_i,
  input  wire acc_cfg_t [ACC_NUM_CMP-1:0] cfg_i,
  input  wire logic [ACC_NUM_CMP-1:0]   raw_result_i,
  input  wire logic                     timer_src_clk_i,
  input  wire logic [ACC_NUM_CMP-1:0]   irq_flag_clear_i,
  input  wire logic [ACC_NUM_CMP-1:0]   irq_enable_i,
  output acc_ana_t [ACC_NUM_CMP-1:0]    analog_ctrl_o,
  output logic [ACC_NUM_CMP-1:0]        output_bit_o,
  output logic [ACC_MIRROR_W-1:0]       mirror_reg_o,
  output logic [ACC_NUM_CMP-1:0]        pin_out_o,
  output logic [ACC_NUM_CMP-1:0]        timer_gate_o,
  output logic [ACC_NUM_CMP-1:0]        irq_flag_o,
  output logic [ACC_NUM_CMP-1:0]        output_valid_o,
  output logic                          wake_o
);

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic acc_ana_t acc_decode(input acc_cfg_t c);
    acc_ana_t a;
    a = '0;
    if (c.enable) begin
      a.pos_pin0 = (c.pos_sel == ACC_SEL_PIN0);
      a.pos_dac  = (c.pos_sel == ACC_SEL_DAC);
      a.pos_ref  = (c.pos_sel == ACC_SEL_REF);
      a.pos_gnd  = (c.pos_sel == ACC_SEL_GND);
      if (c.neg_sel <= ACC_SEL_PIN3) begin
        a.neg_pin[c.neg_sel[1:0]] = 1'b1;
      end
      a.neg_ref  = (c.neg_sel == ACC_SEL_REF);
      a.neg_gnd  = (c.neg_sel == ACC_SEL_GND);
      a.hyst_on  = c.hysteresis;
      a.power_on = 1'b1;
    end
    return a;
  endfunction : acc_decode

  // ---------------------------------------------------------------------
  // Filtering and edge helpers
  // ---------------------------------------------------------------------
  // Level follows the third stage once the second stage agrees with it
  function automatic logic acc_filter(input logic s2,
                                      input logic s3,
                                      input logic q);
    return (s2 == s3) ? s3 : q;
  endfunction : acc_filter

  // Transition between two samples that its enable lets through
  function automatic logic acc_edge(input logic cur,
                                    input logic prev,
                                    input logic rise_en,
                                    input logic fall_en);
    return (cur & ~prev & rise_en) | (~cur & prev & fall_en);
  endfunction : acc_edge

  // ---------------------------------------------------------------------
  // State and intermediate signals
  // ---------------------------------------------------------------------
  logic [ACC_NUM_CMP-1:0]     raw_s1_q;
  logic [ACC_NUM_CMP-1:0]     raw_s2_q;
  logic [ACC_NUM_CMP-1:0]     raw_s3_q;
  logic [ACC_NUM_CMP-1:0]     raw_q;
  logic [ACC_NUM_CMP-1:0]     pol_out;
  logic [ACC_NUM_CMP-1:0]     out_q;
  logic [ACC_NUM_CMP-1:0]     out_prev_q;
  logic [ACC_NUM_CMP-1:0]     sync_q;
  logic [ACC_NUM_CMP-1:0]     flag_q;
  logic [ACC_NUM_CMP-1:0]     flag_d;
  logic [ACC_NUM_CMP-1:0]     edge_hit;
  logic [ACC_NUM_CMP-1:0]     cfg_chg;
  acc_cfg_t [ACC_NUM_CMP-1:0] cfg_prev_q;
  logic [31:0]                settle_q [ACC_NUM_CMP];
  logic                       tclk_s1_q;
  logic                       tclk_s2_q;
  logic                       tclk_s3_q;
  logic                       tclk_q;
  logic                       tclk_fall;

  // ---------------------------------------------------------------------
  // Raw result synchroniser
  // ---------------------------------------------------------------------
  // Analog result crosses in through three stages
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      raw_s1_q <= '0;
      raw_s2_q <= '0;
      raw_s3_q <= '0;
    end else begin
      raw_s1_q <= raw_result_i;
      raw_s2_q <= raw_s1_q;
      raw_s3_q <= raw_s2_q;
    end
  end

  // A change counts once the second and third stages agree
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      raw_q <= '0;
    end else begin
      for (int i = 0; i < ACC_NUM_CMP; i++) begin
        raw_q[i] <= acc_filter(raw_s2_q[i], raw_s3_q[i],
                               raw_q[i]);
      end
    end
  end

  // ---------------------------------------------------------------------
  // Polarity
  // ---------------------------------------------------------------------
  // Disabled comparator shows a low raw result before polarity
  always_comb begin
    for (int i = 0; i < ACC_NUM_CMP; i++) begin
      pol_out[i] = (raw_q[i] & cfg_i[i].enable) ^ cfg_i[i].invert;
    end
  end

  // ---------------------------------------------------------------------
  // Software-visible latch and edge history
  // ---------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      out_q      <= {ACC_NUM_CMP{ACC_OUT_RST}};
      out_prev_q <= {ACC_NUM_CMP{ACC_OUT_RST}};
    end else begin
      out_q      <= pol_out;
      out_prev_q <= out_q;
    end
  end

  // ---------------------------------------------------------------------
  // Timer source clock
  // ---------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      tclk_s1_q <= 1'b0;
      tclk_s2_q <= 1'b0;
      tclk_s3_q <= 1'b0;
      tclk_q    <= 1'b0;
    end else begin
      tclk_s1_q <= timer_src_clk_i;
      tclk_s2_q <= tclk_s1_q;
      tclk_s3_q <= tclk_s2_q;
      tclk_q    <= acc_filter(tclk_s2_q, tclk_s3_q, tclk_q);
    end
  end

  // Fall counts in the cycle in which the agreeing stages first read low
  assign tclk_fall = tclk_q & ~acc_filter(tclk_s2_q, tclk_s3_q, tclk_q);

  // ---------------------------------------------------------------------
  // Synchronised output for timer and pin
  // ---------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      sync_q <= {ACC_NUM_CMP{ACC_OUT_RST}};
    end else begin
      for (int i = 0; i < ACC_NUM_CMP; i++) begin
        if (tclk_fall) begin
          sync_q[i] <= pol_out[i];
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // Interrupt flags
  // ---------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < ACC_NUM_CMP; i++) begin
      // Edges from invert or enable changes flow through the same path
      edge_hit[i] = acc_edge(out_q[i], out_prev_q[i],
                             cfg_i[i].rise_irq_en, cfg_i[i].fall_irq_en);
      // Set wins over a clear in the same cycle
      flag_d[i]   = edge_hit[i] |
                    (flag_q[i] & ~irq_flag_clear_i[i]);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      flag_q <= {ACC_NUM_CMP{ACC_FLAG_RST}};
    end else begin
      flag_q <= flag_d;
    end
  end

  // ---------------------------------------------------------------------
  // Settling watch after any source or reference change
  // ---------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < ACC_NUM_CMP; i++) begin
      cfg_chg[i] = (cfg_i[i].enable     != cfg_prev_q[i].enable) |
                   (cfg_i[i].pos_sel    != cfg_prev_q[i].pos_sel) |
                   (cfg_i[i].neg_sel    != cfg_prev_q[i].neg_sel) |
                   (cfg_i[i].hysteresis != cfg_prev_q[i].hysteresis);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      cfg_prev_q <= '0;
    end else begin
      cfg_prev_q <= cfg_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < ACC_NUM_CMP; i++) begin
        settle_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < ACC_NUM_CMP; i++) begin
        if (cfg_chg[i] || raw_s2_q[i] != raw_s3_q[i]) begin
          settle_q[i] <= 32'(SETTLE_CYC);
        end else if (settle_q[i] != '0) begin
          settle_q[i] <= settle_q[i] - 32'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // Analog front end controls
  // ---------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < ACC_NUM_CMP; i++) begin
      analog_ctrl_o[i] = acc_decode(cfg_i[i]);
    end
  end

  // ---------------------------------------------------------------------
  // Pin, timer and validity outputs
  // ---------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < ACC_NUM_CMP; i++) begin
      output_valid_o[i] = (settle_q[i] == '0) & cfg_i[i].enable;
      pin_out_o[i]      = cfg_i[i].timer_sync ? sync_q[i]
                                              : pol_out[i];
    end
  end

  assign timer_gate_o = pin_out_o;

  // ---------------------------------------------------------------------
  // Software view and interrupt outputs
  // ---------------------------------------------------------------------
  always_comb begin
    mirror_reg_o = ACC_MIRROR_RST;
    for (int i = 0; i < ACC_NUM_CMP; i++) begin
      mirror_reg_o[i] = out_q[i];
    end
  end

  assign output_bit_o = out_q;
  assign irq_flag_o   = flag_q;
  assign wake_o       = |(flag_q & irq_enable_i);

endmodule : acc_ctrl

`default_nettype wire

/* acc_checker.sv */
// Concurrent checks on the comparator control block ports
`timescale 1ns/1ps
`default_nettype none
module acc_checker
  import acc_pkg::*;
(
  input wire logic                       ref_clk_i,
  input wire logic                       rst_b_i,
  input wire acc_cfg_t [ACC_NUM_CMP-1:0] cfg_i,
  input wire logic [ACC_NUM_CMP-1:0]     irq_flag_clear_i,
  input wire logic [ACC_NUM_CMP-1:0]     irq_enable_i,
  input wire acc_ana_t [ACC_NUM_CMP-1:0] analog_ctrl_o,
  input wire logic [ACC_NUM_CMP-1:0]     output_bit_o,
  input wire logic [ACC_MIRROR_W-1:0]    mirror_reg_o,
  input wire logic [ACC_NUM_CMP-1:0]     pin_out_o,
  input wire logic [ACC_NUM_CMP-1:0]     timer_gate_o,
  input wire logic [ACC_NUM_CMP-1:0]     irq_flag_o,
  input wire logic                       wake_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  AST_MIRROR: assert property (
    mirror_reg_o == {6'h00, output_bit_o})
    else $error("mirror register mismatch");
  AST_OFF_OPEN: assert property (
    !cfg_i[0].enable |-> analog_ctrl_o[0] == '0)
    else $error("inputs connected while disabled");
  AST_POS_DAC: assert property (
    cfg_i[0].enable && cfg_i[0].pos_sel == ACC_SEL_DAC
    |-> analog_ctrl_o[0].pos_dac && !analog_ctrl_o[0].pos_pin0)
    else $error("positive select decode wrong");
  AST_NEG_PIN3: assert property (
    cfg_i[0].enable && cfg_i[0].neg_sel == ACC_SEL_PIN3
    |-> analog_ctrl_o[0].neg_pin == 4'h8)
    else $error("negative select decode wrong");
  AST_STICKY: assert property (
    irq_flag_o[0] && !irq_flag_clear_i[0] |=> irq_flag_o[0])
    else $error("flag dropped without clear");
  AST_RISE_SET: assert property (
    $rose(output_bit_o[0]) && cfg_i[0].rise_irq_en |=> irq_flag_o[0])
    else $error("enabled rise did not set flag");
  AST_NO_SPURIOUS: assert property (
    !irq_flag_o[0] && !($rose(output_bit_o[0]) && cfg_i[0].rise_irq_en)
    && !($fell(output_bit_o[0]) && cfg_i[0].fall_irq_en)
    |=> !irq_flag_o[0])
    else $error("flag set without enabled edge");
  AST_WAKE: assert property (
    wake_o == |(irq_flag_o & irq_enable_i))
    else $error("wake request mismatch");
  AST_GATE: assert property (
    !cfg_i[0].timer_sync |=> output_bit_o[0] == $past(timer_gate_o[0]))
    else $error("timer gate differs from unlatched output");
  AST_ASYNC_PIN: assert property (
    !cfg_i[0].timer_sync |=> output_bit_o[0] == $past(pin_out_o[0]))
    else $error("pin output differs from unlatched output");
  // ---------------------------------------------------------------------
  // Coverage
  // ---------------------------------------------------------------------
  cover property ($rose(irq_flag_o[0]));
  cover property (irq_flag_clear_i[0] && irq_flag_o[0]);
  cover property (cfg_i[0].timer_sync && $changed(pin_out_o[0]));
endmodule : acc_checker
bind acc_ctrl acc_checker u_chk (.ref_clk_i, .rst_b_i, .cfg_i,
  .irq_flag_clear_i, .irq_enable_i, .analog_ctrl_o, .output_bit_o,
  .mirror_reg_o, .pin_out_o, .timer_gate_o, .irq_flag_o, .wake_o);
`default_nettype wire

/* acc_front.sv */
// Analog front end and timer clock model for the comparator bench
`timescale 1ns/1ps
`default_nettype none
module acc_front
  import acc_pkg::*;
(
  input  wire logic           ref_clk_i,
  input  wire acc_ana_t [1:0] ana_i,
  input  wire logic [7:0]     vin_i [8],
  input  wire logic [7:0]     analog_sel_i,
  input  wire logic           run_i,
  input  wire logic           pin_i,
  input  wire logic           pin_route_i,
  input  wire logic           pin_dir_i,
  output logic [1:0]          raw_o,
  output logic                tclk_o,
  output logic                pad_o
);
  logic [1:0] div_q = 2'h0;
  initial tclk_o = 1'b0;
  // Unconnected side or powered-down comparator reads low
  function automatic logic cmp(acc_ana_t a);
    int vp;
    int vn;
    vp = -1;
    vn = -1;
    // Pins reach the comparator only when marked analog
    if (a.pos_pin0 && analog_sel_i[0]) vp = vin_i[0];
    if (a.pos_dac) vp = vin_i[1];
    if (a.pos_ref) vp = vin_i[2];
    if (a.pos_gnd) vp = 0;
    for (int k = 0; k < 4; k++)
      if (a.neg_pin[k] && analog_sel_i[4+k]) vn = vin_i[4+k];
    if (a.neg_ref) vn = vin_i[2];
    if (a.neg_gnd) vn = 0;
    return a.power_on && vp >= 0 && vn >= 0 && vp > vn;
  endfunction : cmp
  always_comb raw_o = {cmp(ana_i[1]), cmp(ana_i[0])};
  // Pad shows the output only when routed and driven; else pulled high
  assign pad_o = (pin_route_i && !pin_dir_i) ? pin_i : 1'b1;
  // Timer clock stands still unless run_i
  always @(negedge ref_clk_i) begin
    div_q <= div_q + 2'h1;
    if (run_i && div_q == 2'h3) tclk_o <= ~tclk_o;
  end
endmodule : acc_front
`default_nettype wire

/* tb.sv */
// Self-checking testbench for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import acc_pkg::*;
  logic           clk, rst_b, run, tclk, wake;
  acc_cfg_t [1:0] cfg;
  acc_ana_t [1:0] ana;
  logic [1:0]     raw, clr, ien, obit, pin, gate, flag, vld;
  logic [7:0]     mirror;
  logic [7:0]     vin [8];
  logic [7:0]     analog_sel;
  logic           pin_route, pin_dir, pad;
  int             fail_count = 0;
  int             n_tests = 0;
  acc_ctrl #(.SETTLE_CYC(ACC_SETTLE_CYC)) dut (.ref_clk_i(clk),
    .rst_b_i(rst_b), .cfg_i(cfg), .raw_result_i(raw),
    .timer_src_clk_i(tclk), .irq_flag_clear_i(clr), .irq_enable_i(ien),
    .analog_ctrl_o(ana), .output_bit_o(obit), .mirror_reg_o(mirror),
    .pin_out_o(pin), .timer_gate_o(gate), .irq_flag_o(flag),
    .output_valid_o(vld), .wake_o(wake));
  acc_front u_front (.ref_clk_i(clk), .ana_i(ana), .vin_i(vin),
    .analog_sel_i(analog_sel), .run_i(run), .pin_i(pin[0]),
    .pin_route_i(pin_route), .pin_dir_i(pin_dir), .raw_o(raw),
    .tclk_o(tclk), .pad_o(pad));
  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict();
    if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic settle(input int c);
    int n;
    n = 0;
    repeat (2) @(negedge clk);
    while (vld[c] !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (vld[c] !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
    repeat (6) @(negedge clk);
  endtask : settle
  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_select();
    cfg[0].enable = 1'b1;
    cfg[1].enable = 1'b1;
    cfg[1].neg_sel = ACC_SEL_GND;
    for (int i = 0; i < 16; i++) begin
      cfg[0].neg_sel = i[2:0];
      cfg[0].invert = i[3];
      cfg[1].pos_sel = i[2:0];
      settle(0);
      chk(obit[0], 8'h83 >> i[2:0] & 1 ^ i[3]);
      chk(mirror[0], 8'h83 >> i[2:0] & 1 ^ i[3]);
      chk(mirror[1], 8'h61 >> i[2:0] & 1);
      chk(mirror[7:2], 6'h00);
    end
  endtask : t_select
  task automatic t_off();
    cfg[0] = '0;
    cfg[0].invert = 1'b1;
    cfg[0].hysteresis = 1'b1;
    repeat (8) @(negedge clk);
    chk(ana[0], '0);
    chk(obit[0], 1'b1);
    cfg[0].enable = 1'b1;
    repeat (2) @(negedge clk);
    chk(vld[0], 1'b0);
    chk({ana[0].power_on, ana[0].hyst_on}, 2'h3);
    cfg[0].hysteresis = 1'b0;
    @(negedge clk);
    chk(ana[0].hyst_on, 1'b0);
  endtask : t_off
  task automatic t_irq();
    int n;
    cfg[0] = '0;
    cfg[0].rise_irq_en = 1'b1;
    ien[0] = 1'b1;
    clr[0] = 1'b1;
    repeat (8) @(negedge clk);
    clr[0] = 1'b0;
    cfg[0].invert = 1'b1;
    repeat (8) @(negedge clk);
    chk(flag[0], 1'b1);
    chk(wake, 1'b1);
    repeat (20) @(negedge clk);
    chk(flag[0], 1'b1);
    clr[0] = 1'b1;
    @(negedge clk);
    clr[0] = 1'b0;
    cfg[0].invert = 1'b0;
    repeat (8) @(negedge clk);
    chk({flag[0], wake}, 2'h0);
    cfg[0].rise_irq_en = 1'b0;
    cfg[0].fall_irq_en = 1'b1;
    cfg[0].invert = 1'b1;
    repeat (8) @(negedge clk);
    chk(flag[0], 1'b0);
    cfg[0].invert = 1'b0;
    repeat (8) @(negedge clk);
    chk(flag[0], 1'b1);
    cfg[0].rise_irq_en = 1'b1;
    cfg[0].invert = 1'b1;
    n = 0;
    while (obit[0] !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (obit[0] !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
    clr[0] = 1'b1;
    @(negedge clk);
    clr[0] = 1'b0;
    @(negedge clk);
    chk(flag[0], 1'b1);
  endtask : t_irq
  task automatic t_sync();
    int n;
    cfg[0] = '0;
    cfg[0].enable = 1'b1;
    cfg[0].neg_sel = ACC_SEL_GND;
    pin_route = 1'b1;
    pin_dir = 1'b0;
    vin[0] = 8'h00;
    settle(0);
    vin[0] = 8'h32;
    n = 0;
    while (pin[0] !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (pin[0] !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
    chk(obit[0], 1'b0);
    repeat (6) @(negedge clk);
    chk({obit[0], gate[0]}, 2'h3);
    cfg[0].timer_sync = 1'b1;
    run = 1'b1;
    repeat (40) @(negedge clk);
    run = 1'b0;
    repeat (8) @(negedge clk);
    vin[0] = 8'h00;
    repeat (10) @(negedge clk);
    chk({obit[0], pin[0], gate[0]}, 3'h3);
    run = 1'b1;
    repeat (40) @(negedge clk);
    chk({pin[0], gate[0], pad}, 3'h0);
    run = 1'b0;
  endtask : t_sync
  // ---------------------------------------------------------------------
  // Clock and main sequence
  // ---------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    rst_b = 1'b0;
    run = 1'b0;
    cfg = '0;
    clr = 2'h0;
    ien = 2'h0;
    vin = '{8'h32, 8'h1E, 8'hC8, 8'h00, 8'h00, 8'h28, 8'h50, 8'h78};
    analog_sel = 8'hF1;
    pin_route = 1'b0;
    pin_dir = 1'b1;
    repeat (2) @(negedge clk);
    chk({flag, mirror}, 10'h000);
    chk(pad, 1'b1);
    rst_b = 1'b1;
    t_select();
    t_off();
    t_irq();
    t_sync();
    print_verdict();
  end
endmodule : tb
`default_nettype wire
